// ===== src/hp_cfg.svh
// constants of the register access host port
`ifndef HP_CFG_SVH
`define HP_CFG_SVH

// device register and port indices
`define IDX_CONFIG       7'h00
`define IDX_GPIO_DIR     7'h01
`define IDX_GPIO_OUT     7'h02
`define IDX_GPIO_IN      7'h03
`define IDX_IRQ_FLAG     7'h04
`define IDX_LAST_REG     7'h07
`define IDX_PORT         7'h08

// config register fields and reset value
`define CFG_HOST_EN      0
`define CFG_PASSIVE_FIFO 1
`define CFG_IRQ_EN       2
`define CONFIG_RESET     8'h01

// command byte direction bit, one means read
`define CMD_READ_BIT     7

// byte port depth
`define PORT_DEPTH       3'h4

// controller registers, byte offsets on the avalon slave
`define AV_ADDR          5'h00
`define AV_DATA          5'h04
`define AV_RDSTART       5'h08
`define AV_RDATA         5'h0c
`define AV_STATUS        5'h10
`define AV_IRQ_STATUS    5'h14
`define AV_IRQ_MASK      5'h18

// controller interrupt status bits
`define IRQ_READ_DONE    0
`define IRQ_DEVICE       1

`endif

// ===== src/hp_pkg.sv
// types of the register access host port
package hp_pkg;

   typedef enum logic [1:0] {PH_IDLE, PH_STROBE, PH_GAP} phase_type;

   typedef struct packed {
      logic [7:0][7:0] regs;
      logic [3:0][7:0] mem;
      logic [1:0]      wrPtr;
      logic [1:0]      rdPtr;
      logic [2:0]      count;
      logic [7:0]      hostCmd;
      logic            hostUsed;
      logic [7:0]      linkCmd;
      logic            linkUsed;
      logic [7:0]      lastRead;
      logic [7:0]      busOut;
      logic [7:0]      busOeN;
      logic            irqN;
      logic            linkTxValid;
      logic [7:0]      linkTxByte;
      logic            adcDacAvailable;
   } dev_state_type;

   typedef struct packed {
      phase_type       phase;
      logic            sel;
      logic            wnr;
      logic            dna;
      logic [7:0]      busOut;
      logic [7:0]      busOeN;
      logic            readPending;
      logic [7:0]      rdata;
      logic [1:0]      irqStatus;
      logic [1:0]      irqMask;
      logic            waitReq;
      logic [31:0]     readData;
      logic            irq;
   } ctl_state_type;

endpackage

// ===== src/hp_if.sv
// pins between the host controller and the device host port
`timescale 1ns/100ps
interface hp_if;
   logic       hostSelectN;
   logic       hostWriteNotRead;
   logic       hostDataNotAddress;
   logic [7:0] hostBusOut;
   logic [7:0] hostBusOeN;
   logic [7:0] devBusOut;
   logic [7:0] devBusOeN;
   logic [7:0] hostDataBus;
   logic       hostInterruptRequestN;

   // resolved bus level, undriven bits float high on pull-ups
   assign hostDataBus = (devBusOut & ~devBusOeN)
                      | (hostBusOut & ~hostBusOeN & devBusOeN)
                      | (devBusOeN & hostBusOeN);

   modport device (
      input  hostSelectN,
      input  hostWriteNotRead,
      input  hostDataNotAddress,
      input  hostDataBus,
      output devBusOut,
      output devBusOeN,
      output hostInterruptRequestN
   );

   modport controller (
      output hostSelectN,
      output hostWriteNotRead,
      output hostDataNotAddress,
      output hostBusOut,
      output hostBusOeN,
      input  hostDataBus,
      input  hostInterruptRequestN
   );
endinterface

// ===== src/host_port_device.sv
// device end: command decoder, registers and byte port
//
// Contract
// - transaction is command byte plus data bytes
// - command bit7 one reads, zero writes
// - all registers eight bits, two commands
// - register moves one byte, port many
// - packet access on ports, many bytes
// - select low to access, strobes ignored otherwise
// - write-not-read high writes, low reads
// - data-not-address picks data or address register
// - data bus doubles as gpio when disabled
// - active low interrupt request to host
// - config register picks host or gpio pins
// - passive fifo mode disables adc and dac
// - config accepted from link or host port
`timescale 1ns/100ps
`include "hp_cfg.svh"
module host_port_device
   import hp_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // host pins
   hp_if.device            port,
   // bytes from the serial link
   input  wire logic       linkRxValid,
   input  wire logic       linkRxFirst,
   input  wire logic [7:0] linkRxByte,
   // read replies to the serial link
   output      logic       linkTxValid,
   output      logic [7:0] linkTxByte,
   // events and pin sharing
   input  wire logic       deviceEvent,
   output      logic       adcDacAvailable
);

   dev_state_type s;
   dev_state_type next_s;

   // true for the address of a byte port
   function automatic logic isPort(input logic [6:0] idx);
      return idx == `IDX_PORT;
   endfunction

   // register slot of an index
   function automatic logic [2:0] slot(input logic [6:0] idx);
      return idx[2:0];
   endfunction

   // one byte access to a register or the port
   function automatic dev_state_type access(
      input dev_state_type st,
      input logic          rd,
      input logic [6:0]    idx,
      input logic [7:0]    wd,
      input logic [7:0]    pins
   );
      dev_state_type r;
      r = st;
      r.lastRead = 8'h00;
      if (isPort(idx))
      begin
         if (rd && st.count != 3'h0)
         begin
            r.lastRead = st.mem[st.rdPtr];
            r.rdPtr    = st.rdPtr + 2'h1;
            r.count    = st.count - 3'h1;
         end
         else if (!rd && st.count != `PORT_DEPTH)
         begin
            r.mem[st.wrPtr] = wd;
            r.wrPtr         = st.wrPtr + 2'h1;
            r.count         = st.count + 3'h1;
         end
      end
      else if (idx == `IDX_GPIO_IN)
      begin
         if (rd)
            r.lastRead = pins;
      end
      else if (idx == `IDX_IRQ_FLAG)
      begin
         if (rd)
            r.lastRead = st.regs[slot(idx)];
         else
            r.regs[slot(idx)] = st.regs[slot(idx)] & ~wd; // one clears
      end
      else if (idx <= `IDX_LAST_REG)
      begin
         if (rd)
            r.lastRead = st.regs[slot(idx)];
         else
            r.regs[slot(idx)] = wd;
      end
      return r;
   endfunction

   // decode host strobes and link bytes into accesses
   always_comb
   begin
      logic       hostEn;
      logic       strobe;
      logic       hostReadAns;
      logic [7:0] hostAns;
      logic [7:0] flags;
      logic [7:0] cfg;
      next_s             = s;
      next_s.linkTxValid = 1'b0;
      hostEn      = s.regs[slot(`IDX_CONFIG)][`CFG_HOST_EN];
      hostReadAns = 1'b0;
      hostAns     = 8'h00;
      flags       = 8'h00;
      cfg         = 8'h00;
      strobe = hostEn & ~port.hostSelectN;
      if (strobe)
      begin
         if (!port.hostDataNotAddress)
         begin
            if (port.hostWriteNotRead)
            begin
               next_s.hostCmd  = port.hostDataBus;
               next_s.hostUsed = 1'b0;
            end
            else
            begin
               hostReadAns = 1'b1;
               hostAns     = s.hostCmd;
            end
         end
         else if (port.hostWriteNotRead != s.hostCmd[`CMD_READ_BIT]
                  && !(s.hostUsed && !isPort(s.hostCmd[6:0])))
         begin
            next_s = access(next_s, s.hostCmd[`CMD_READ_BIT],
                            s.hostCmd[6:0], port.hostDataBus,
                            port.hostDataBus);
            next_s.hostUsed = 1'b1;
            hostReadAns     = ~port.hostWriteNotRead;
            hostAns         = next_s.lastRead;
         end
         else
            hostReadAns = ~port.hostWriteNotRead; // refused read gives 0
      end
      if (linkRxValid)
      begin
         if (linkRxFirst)
         begin
            next_s.linkCmd  = linkRxByte;
            next_s.linkUsed = 1'b0;
            if (linkRxByte[`CMD_READ_BIT] && !isPort(linkRxByte[6:0]))
            begin
               next_s = access(next_s, 1'b1, linkRxByte[6:0], 8'h00,
                               port.hostDataBus);
               next_s.linkUsed    = 1'b1;
               next_s.linkTxValid = 1'b1;
               next_s.linkTxByte  = next_s.lastRead;
            end
         end
         else if (!(s.linkUsed && !isPort(s.linkCmd[6:0])))
         begin
            next_s = access(next_s, s.linkCmd[`CMD_READ_BIT],
                            s.linkCmd[6:0], linkRxByte, port.hostDataBus);
            next_s.linkUsed = 1'b1;
            if (s.linkCmd[`CMD_READ_BIT])
            begin
               next_s.linkTxValid = 1'b1;
               next_s.linkTxByte  = next_s.lastRead;
            end
         end
      end
      // event sets the flag, winning over a clear
      next_s.regs[slot(`IDX_IRQ_FLAG)][0] =
         next_s.regs[slot(`IDX_IRQ_FLAG)][0] | deviceEvent;
      cfg   = next_s.regs[slot(`IDX_CONFIG)];
      flags = next_s.regs[slot(`IDX_IRQ_FLAG)];
      if (!cfg[`CFG_HOST_EN])
      begin
         next_s.busOeN = ~next_s.regs[slot(`IDX_GPIO_DIR)];
         next_s.busOut = next_s.regs[slot(`IDX_GPIO_OUT)];
      end
      else if (hostReadAns)
      begin
         next_s.busOeN = 8'h00;
         next_s.busOut = hostAns;
      end
      else
         next_s.busOeN = 8'hff;
      next_s.irqN = ~((|flags) & cfg[`CFG_IRQ_EN]);
      // passive fifo takes adc dac pins
      next_s.adcDacAvailable = ~cfg[`CFG_PASSIVE_FIFO];
   end

   // state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s                                 <= '0;
         s.regs[slot(`IDX_CONFIG)]         <= `CONFIG_RESET;
         s.busOeN                          <= 8'hff;
         s.irqN                            <= 1'b1;
         s.adcDacAvailable                 <= 1'b1;
      end
      else
         s <= next_s;
   end

   // outputs straight from the state
   assign port.devBusOut            = s.busOut;
   assign port.devBusOeN            = s.busOeN;
   assign port.hostInterruptRequestN = s.irqN;
   assign linkTxValid               = s.linkTxValid;
   assign linkTxByte                = s.linkTxByte;
   assign adcDacAvailable           = s.adcDacAvailable;

endmodule

// ===== src/host_port_controller.sv
// host end: avalon slave that runs host port cycles
`timescale 1ns/100ps
`include "hp_cfg.svh"
module host_port_controller
   import hp_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // host pins
   hp_if.controller         port,
   // avalon-mm slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output      logic [31:0] readdata,
   output      logic        waitrequest,
   // interrupt
   output      logic        irq
);

   ctl_state_type s;
   ctl_state_type next_s;

   // bus requests, one host cycle engine, interrupt status
   always_comb
   begin
      logic req;
      logic startsCycle;
      next_s         = s;
      next_s.waitReq = 1'b1;
      req = (read | write) & s.waitReq;
      startsCycle = write & (address == `AV_ADDR || address == `AV_DATA
                             || address == `AV_RDSTART);
      // a cycle starts only when idle
      if (req && !(startsCycle && s.phase != PH_IDLE))
      begin
         next_s.waitReq  = 1'b0;
         next_s.readData = 32'h0000_0000;
         if (write)
         begin
            if (startsCycle)
            begin
               next_s.phase = PH_STROBE;
               next_s.sel   = 1'b0;
               next_s.wnr   = address != `AV_RDSTART;
               next_s.dna   = (address == `AV_RDSTART) ? writedata[0]
                                                      : (address == `AV_DATA);
               next_s.busOut      = writedata[7:0];
               next_s.busOeN      = (address == `AV_RDSTART) ? 8'hff : 8'h00;
               next_s.readPending = address == `AV_RDSTART;
            end
            else if (address == `AV_IRQ_MASK)
               next_s.irqMask = writedata[1:0];
         end
         else
         begin
            case (address)
               `AV_RDATA:      next_s.readData = {24'h00_0000, s.rdata};
               `AV_STATUS:     next_s.readData = {31'h0, s.phase != PH_IDLE};
               `AV_IRQ_MASK:   next_s.readData = {30'h0, s.irqMask};
               `AV_IRQ_STATUS:
               begin
                  next_s.readData  = {30'h0, s.irqStatus};
                  next_s.irqStatus = 2'b00;
               end
               default:        next_s.readData = 32'h0000_0000;
            endcase
         end
      end
      // strobe lasts one cycle, then one gap cycle
      case (s.phase)
         PH_IDLE: ;
         PH_STROBE:
         begin
            next_s.sel    = 1'b1;
            next_s.busOeN = 8'hff;
            next_s.phase  = PH_GAP;
         end
         PH_GAP:
         begin
            if (s.readPending)
            begin
               next_s.rdata                    = port.hostDataBus;
               next_s.irqStatus[`IRQ_READ_DONE] = 1'b1;
               next_s.readPending              = 1'b0;
            end
            next_s.phase = PH_IDLE;
         end
         default: next_s.phase = PH_IDLE;
      endcase
      if (!port.hostInterruptRequestN)
         next_s.irqStatus[`IRQ_DEVICE] = 1'b1;
      next_s.irq = |(next_s.irqStatus & next_s.irqMask);
   end

   // state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s         <= '0;
         s.phase   <= PH_IDLE;
         s.sel     <= 1'b1;
         s.busOeN  <= 8'hff;
         s.waitReq <= 1'b1;
      end
      else
         s <= next_s;
   end

   // outputs straight from the state
   assign port.hostSelectN        = s.sel;
   assign port.hostWriteNotRead   = s.wnr;
   assign port.hostDataNotAddress = s.dna;
   assign port.hostBusOut         = s.busOut;
   assign port.hostBusOeN         = s.busOeN;
   assign readdata                = s.readData;
   assign waitrequest             = s.waitReq;
   assign irq                     = s.irq;

endmodule

// ===== tb/host_port_monitor.sv
// checker of the host port pin timing between the two ends
`timescale 1ns/100ps
module host_port_monitor (
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // host pins
   input wire logic       hostSelectN,
   input wire logic       hostWriteNotRead,
   input wire logic [7:0] hostBusOeN,
   input wire logic [7:0] devBusOeN
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // strobe kinds and the device answer
   sequence s_rd_strobe;
      !hostSelectN && !hostWriteNotRead;
   endsequence
   sequence s_wr_strobe;
      !hostSelectN && hostWriteNotRead;
   endsequence
   sequence s_answer;
      devBusOeN == 8'h00 ##1 devBusOeN == 8'hff;
   endsequence

   property p_sel_short;
      $fell(hostSelectN) |=> hostSelectN;
   endproperty
   property p_idle_release;
      hostSelectN |-> hostBusOeN == 8'hff;
   endproperty
   property p_wr_drive;
      s_wr_strobe |-> hostBusOeN == 8'h00;
   endproperty
   property p_wr_quiet;
      s_wr_strobe |=> devBusOeN == 8'hff;
   endproperty
   property p_rd_release;
      s_rd_strobe |-> hostBusOeN == 8'hff;
   endproperty
   property p_rd_answer;
      s_rd_strobe ##0 devBusOeN == 8'hff |=> s_answer;
   endproperty
   property p_rd_gap;
      s_rd_strobe |=> hostSelectN;
   endproperty
   property p_no_clash;
      (devBusOeN | hostBusOeN) == 8'hff;
   endproperty

   a_sel_short: assert property (p_sel_short)
      else $error("select held low beyond one cycle");
   a_idle_release: assert property (p_idle_release)
      else $error("host drives bus while not selected");
   a_wr_drive: assert property (p_wr_drive)
      else $error("host not driving during write strobe");
   a_wr_quiet: assert property (p_wr_quiet)
      else $error("device answered a write strobe");
   a_rd_release: assert property (p_rd_release)
      else $error("host drives bus during read strobe");
   a_rd_answer: assert property (p_rd_answer)
      else $error("device read answer missing or too long");
   a_rd_gap: assert property (p_rd_gap)
      else $error("select low during read answer");
   a_no_clash: assert property (p_no_clash)
      else $error("both ends drive the data bus");
endmodule

// ===== tb/test_register_access_host_port.sv
// self-checking bench joining controller and device ends
`timescale 1ns/100ps
`include "hp_cfg.svh"
module test_register_access_host_port;
   logic        clk;
   logic        rstn;
   logic [4:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        irq;
   logic        linkRxValid;
   logic        linkRxFirst;
   logic [7:0]  linkRxByte;
   logic        linkTxValid;
   logic [7:0]  linkTxByte;
   logic        deviceEvent;
   logic        adcDacAvailable;
   logic [7:0]  txSeen = 8'h00;
   logic [7:0]  k;
   logic [31:0] rd;
   int          fails;
   int          checksDone;

   hp_if pins ();
   host_port_device i_host_port_device (.clk(clk), .rstn(rstn),
      .port(pins), .linkRxValid(linkRxValid), .linkRxFirst(linkRxFirst),
      .linkRxByte(linkRxByte), .linkTxValid(linkTxValid),
      .linkTxByte(linkTxByte), .deviceEvent(deviceEvent),
      .adcDacAvailable(adcDacAvailable));
   host_port_controller i_host_port_controller (.clk(clk), .rstn(rstn),
      .port(pins), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq));
   host_port_monitor i_host_port_monitor (.clk(clk), .rstn(rstn),
      .hostSelectN(pins.hostSelectN),
      .hostWriteNotRead(pins.hostWriteNotRead),
      .hostBusOeN(pins.hostBusOeN), .devBusOeN(pins.devBusOeN));

   // free running clock
   always #4 clk = ~clk;

   // keep the last link reply
   always @(posedge clk)
      if (linkTxValid === 1'b1)
         txSeen <= linkTxByte;

   task end_of_test;
      $display("comparisons %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon cycle, held until waitrequest is seen low
   task av(input logic wr, input logic [4:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= ~wr;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 200);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (n >= 200)
      begin
         fails++;
         end_of_test;
      end
   endtask

   // read strobe, wait while busy, fetch the byte
   task rd_data(input logic dna);
      int n;
      av(1'b1, `AV_RDSTART, {7'h0, dna});
      rd = 32'h1;
      n = 0;
      while (rd[0] !== 1'b0 && n < 20)
      begin
         av(1'b0, `AV_STATUS, 8'h00);
         n++;
      end
      // a host cycle that never ends counts as a mismatch
      if (rd[0] !== 1'b0)
      begin
         fails++;
         end_of_test;
      end
      av(1'b0, `AV_RDATA, 8'h00);
   endtask

   task link(input logic first, input logic [7:0] b);
      @(posedge clk);
      linkRxValid <= 1'b1;
      linkRxFirst <= first;
      linkRxByte <= b;
      @(posedge clk);
      linkRxValid <= 1'b0;
   endtask

   // watchdog
   initial
   begin
      repeat (50000) @(posedge clk);
      fails++;
      end_of_test;
   end

   // main sequence
   initial
   begin
      clk = 0;
      rstn = 0;
      {read, write, address, writedata} = '0;
      {linkRxValid, linkRxFirst, linkRxByte, deviceEvent} = '0;
      fails = 0;
      checksDone = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check(pins.hostSelectN, 32'h1);
      check(pins.hostInterruptRequestN, 32'h1);
      check(adcDacAvailable, 32'h1);
      check(irq, 32'h0);
      av(1'b0, 5'h1c, 8'h00);
      check(rd, 32'h0);
      $display("reset test done");
      for (k = 8'h05; k < 8'h08; k++)
      begin
         av(1'b1, `AV_ADDR, k);
         av(1'b1, `AV_DATA, k ^ 8'ha5);
         av(1'b1, `AV_DATA, 8'h00);
      end
      for (k = 8'h05; k < 8'h08; k++)
      begin
         av(1'b1, `AV_ADDR, k | 8'h80);
         rd_data(1'b1);
         check(rd, {24'h0, k ^ 8'ha5});
      end
      rd_data(1'b0);
      check(rd, 32'h87);
      av(1'b1, `AV_ADDR, 8'h80);
      rd_data(1'b1);
      check(rd, 32'h01);
      av(1'b1, `AV_ADDR, 8'h05);
      rd_data(1'b1);
      check(rd, 32'h0);
      // data write under a read command must be ignored
      av(1'b1, `AV_ADDR, 8'h85);
      av(1'b1, `AV_DATA, 8'h77);
      rd_data(1'b1);
      check(rd, 32'ha0);
      // only the latest address counts
      av(1'b1, `AV_ADDR, 8'h86);
      av(1'b1, `AV_ADDR, 8'h87);
      rd_data(1'b1);
      check(rd, 32'ha2);
      // pin read sees the released bus on its pull-ups
      av(1'b1, `AV_ADDR, 8'h83);
      rd_data(1'b1);
      check(rd, 32'hff);
      $display("register test done");
      av(1'b1, `AV_ADDR, 8'h08);
      for (k = 8'h01; k < 8'h06; k++)
         av(1'b1, `AV_DATA, k * 8'h11);
      av(1'b1, `AV_ADDR, 8'h88);
      for (k = 8'h01; k < 8'h06; k++)
      begin
         rd_data(1'b1);
         check(rd, {24'h0, (k < 8'h05) ? k * 8'h11 : 8'h00});
      end
      $display("port test done");
      link(1'b1, 8'h06);
      link(1'b0, 8'h3c);
      link(1'b1, 8'h86);
      repeat (2) @(posedge clk);
      check(txSeen, 32'h3c);
      av(1'b1, `AV_ADDR, 8'h86);
      rd_data(1'b1);
      check(rd, 32'h3c);
      $display("link test done");
      av(1'b1, `AV_ADDR, 8'h00);
      av(1'b1, `AV_DATA, 8'h05);
      @(posedge clk);
      deviceEvent <= 1'b1;
      @(posedge clk);
      deviceEvent <= 1'b0;
      repeat (3) @(posedge clk);
      check(pins.hostInterruptRequestN, 32'h0);
      check(irq, 32'h0);
      av(1'b1, `AV_IRQ_MASK, 8'h03);
      repeat (2) @(posedge clk);
      check(irq, 32'h1);
      av(1'b1, `AV_ADDR, 8'h04);
      av(1'b1, `AV_DATA, 8'h01);
      repeat (3) @(posedge clk);
      check(pins.hostInterruptRequestN, 32'h1);
      av(1'b0, `AV_IRQ_STATUS, 8'h00);
      check(rd, 32'h3);
      av(1'b0, `AV_IRQ_STATUS, 8'h00);
      check(rd, 32'h0);
      repeat (2) @(posedge clk);
      check(irq, 32'h0);
      $display("interrupt test done");
      av(1'b1, `AV_ADDR, 8'h00);
      av(1'b1, `AV_DATA, 8'h03);
      repeat (2) @(posedge clk);
      check(adcDacAvailable, 32'h0);
      av(1'b1, `AV_ADDR, 8'h00);
      av(1'b1, `AV_DATA, 8'h01);
      repeat (2) @(posedge clk);
      check(adcDacAvailable, 32'h1);
      $display("pin mode test done");
      av(1'b1, `AV_ADDR, 8'h01);
      av(1'b1, `AV_DATA, 8'hff);
      av(1'b1, `AV_ADDR, 8'h02);
      av(1'b1, `AV_DATA, 8'h5a);
      // host port off from the link, so no host strobe sees gpio drive
      link(1'b1, 8'h00);
      link(1'b0, 8'h00);
      repeat (3) @(posedge clk);
      check(pins.hostDataBus, 32'h5a);
      link(1'b1, 8'h00);
      link(1'b0, 8'h01);
      repeat (3) @(posedge clk);
      check(pins.hostDataBus, 32'hff);
      $display("gpio test done");
      end_of_test;
   end
endmodule
